// ===== dirq_map.svh
// register offsets, field positions and reset values of the interrupt block
`ifndef DIRQ_MAP_SVH
`define DIRQ_MAP_SVH

// ************************************************************
// register offsets
// ************************************************************
`define DIRQ_OFS_FLAG       16'h1000
`define DIRQ_OFS_FLAG_SET   16'h1004
`define DIRQ_OFS_FLAG_CLEAR 16'h1008
`define DIRQ_OFS_ENABLE     16'h100C

// ************************************************************
// field positions and reset values
// ************************************************************
`define DIRQ_ERR_BIT        31
`define DIRQ_CHAN_MSB       7
`define DIRQ_CHAN_LSB       0
`define DIRQ_FLAG_RESET     9'h000
`define DIRQ_ENABLE_RESET   9'h000
`define DIRQ_RDATA_RESET    32'h0000_0000

`endif

// ===== dirq_pkg.sv
// types shared by the interrupt block
package dirq_pkg;
    // ************************************************************
    // flag and enable layout: bus error plus eight channels
    // ************************************************************
    typedef struct packed {
        logic       bus_err;
        logic [7:0] chan_complete;
    } dirq_bits_t;

    // ************************************************************
    // register port request
    // ************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } dirq_req_t;
endpackage : dirq_pkg

// ===== dirq_events.sv
// event synchroniser and edge detector for the flag sources
`timescale 1ns/100ps
`default_nettype none
module dirq_events (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire dirq_pkg::dirq_bits_t lvl_in,
    output var  dirq_pkg::dirq_bits_t rise
);
    dirq_pkg::dirq_bits_t sync1_q, sync1_d;
    dirq_pkg::dirq_bits_t sync2_q, sync2_d;
    dirq_pkg::dirq_bits_t prev_q,  prev_d;
    dirq_pkg::dirq_bits_t rise_q,  rise_d;

    // ************************************************************
    // two stages, then one-cycle pulse on each rising level
    // ************************************************************
    always_comb begin
        sync1_d = lvl_in;
        sync2_d = sync1_q;
        prev_d  = sync2_q;
        rise_d  = sync2_q & ~prev_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
            rise_q  <= '0;
        end else if (ce) begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
            rise_q  <= rise_d;
        end
    end

    assign rise = rise_q;
endmodule : dirq_events
`default_nettype wire

// ===== dirq_ctrl.sv
// interrupt flags, flag set and clear, enables and request output of the dma
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "dirq_map.svh"
module dirq_ctrl (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CLK_EN,
    input  wire logic        BUS_ERROR,
    input  wire logic [7:0]  CHAN_DONE,
    input  wire logic [7:0]  CHAN_REQUEST,
    input  wire logic [7:0]  CHAN_ENABLED,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output var  logic [31:0] REG_RDATA,
    output var  logic        DMA_IRQ
);
    dirq_pkg::dirq_req_t  req;
    dirq_pkg::dirq_bits_t src_lvl;
    dirq_pkg::dirq_bits_t src_rise;
    dirq_pkg::dirq_bits_t flag_q,   flag_d;
    dirq_pkg::dirq_bits_t enable_q, enable_d;
    dirq_pkg::dirq_bits_t set_mask;
    dirq_pkg::dirq_bits_t clr_mask;
    logic [31:0]          rdata_q,  rdata_d;

    // ************************************************************
    // helpers
    // ************************************************************
    // reserved bits 30..8 are dropped here, so stray ones have no effect
    function automatic dirq_pkg::dirq_bits_t pick(input logic [31:0] w);
        pick.bus_err       = w[`DIRQ_ERR_BIT];
        pick.chan_complete = w[`DIRQ_CHAN_MSB:`DIRQ_CHAN_LSB];
    endfunction : pick

    function automatic logic [31:0] spread(input dirq_pkg::dirq_bits_t b);
        spread = {b.bus_err, 23'h00_0000, b.chan_complete};
    endfunction : spread

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

    // ************************************************************
    // event sources
    // ************************************************************
    // level sources arrive from other logic; edge detect makes each a pulse
    always_comb begin
        src_lvl.bus_err       = BUS_ERROR;
        src_lvl.chan_complete = CHAN_DONE | (CHAN_REQUEST & ~CHAN_ENABLED);
    end

    dirq_events u_events (
        .clk    (CLK),
        .rst    (SYS_RST),
        .ce     (CLK_EN),
        .lvl_in (src_lvl),
        .rise   (src_rise)
    );

    // ************************************************************
    // flags and enables
    // ************************************************************
    always_comb begin
        set_mask = '0;
        clr_mask = '0;
        enable_d = enable_q;
        if (req.wr && hit(req.addr, `DIRQ_OFS_FLAG_SET)) begin
            set_mask = pick(req.wdata);
        end
        if (req.wr && hit(req.addr, `DIRQ_OFS_FLAG_CLEAR)) begin
            clr_mask = pick(req.wdata);
        end
        if (req.wr && hit(req.addr, `DIRQ_OFS_ENABLE)) begin
            enable_d = pick(req.wdata);
        end
        // an event in the clearing cycle wins; the bus error state itself
        // lives in the engine and is not released here
        flag_d = (flag_q & ~clr_mask) | set_mask | src_rise;
    end

    // ************************************************************
    // read port
    // ************************************************************
    always_comb begin
        rdata_d = `DIRQ_RDATA_RESET;
        if (req.rd) begin
            if (hit(req.addr, `DIRQ_OFS_FLAG)) begin
                rdata_d = spread(flag_q);
            end else if (hit(req.addr, `DIRQ_OFS_ENABLE)) begin
                rdata_d = spread(enable_q);
            end else begin
                rdata_d = `DIRQ_RDATA_RESET;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            flag_q   <= `DIRQ_FLAG_RESET;
            enable_q <= `DIRQ_ENABLE_RESET;
            rdata_q  <= `DIRQ_RDATA_RESET;
        end else if (CLK_EN) begin
            flag_q   <= flag_d;
            enable_q <= enable_d;
            rdata_q  <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign DMA_IRQ   = |(flag_q & enable_q);
endmodule : dirq_ctrl
`default_nettype wire

// ===== dirq_assertions.sv
// port assertions of the dma interrupt flag block
`timescale 1ns/100ps
`default_nettype none
module dirq_assertions (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        CLK_EN,
    input wire logic        BUS_ERROR,
    input wire logic [7:0]  CHAN_DONE,
    input wire logic [7:0]  CHAN_REQUEST,
    input wire logic [7:0]  CHAN_ENABLED,
    input wire logic [15:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic        DMA_IRQ
);
    // ****
    // checks
    // ****
    // quiet for six cycles: nothing left in the edge pipeline
    wire logic q = CLK_EN && !BUS_ERROR && !CHAN_DONE && !(CHAN_REQUEST & ~CHAN_ENABLED);
    wire logic we = CLK_EN && REG_WR && REG_ADDR == 16'h100C;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    AST_RST_ZERO: assert property ($past(SYS_RST) && $past(CLK_EN) |-> !REG_RDATA && !DMA_IRQ)
        else $error("outputs not clear after reset");
    AST_RSVD_ZERO: assert property (REG_RDATA[30:8] == 23'h00_0000)
        else $error("reserved read bits set");
    AST_RD_IDLE: assert property ($past(CLK_EN) && !$past(REG_RD) |-> !REG_RDATA)
        else $error("read data without a read");
    AST_EN_RB: assert property (we ##1 CLK_EN && REG_RD && REG_ADDR == 16'h100C
        |=> REG_RDATA == ($past(REG_WDATA, 2) & 32'h8000_00FF)) else $error("enable readback");
    AST_MASK: assert property (we && !(REG_WDATA & 32'h8000_00FF) |=> !DMA_IRQ)
        else $error("irq with all enables off");
    AST_CLR_ALL: assert property (q [*6] ##0 REG_WR && REG_ADDR == 16'h1008
        && REG_WDATA == 32'h8000_00FF |=> !DMA_IRQ) else $error("irq after clear all");
    AST_SET: assert property (we && REG_WDATA[31] ##1 CLK_EN && REG_WR
        && REG_ADDR == 16'h1004 && REG_WDATA[31] |=> DMA_IRQ) else $error("set did not raise irq");
    AST_STICKY: assert property ($fell(DMA_IRQ) |-> $past(REG_WR))
        else $error("irq dropped without a write");
endmodule : dirq_assertions
`default_nettype wire

// ===== test_dma_irq_clear_enable.sv
// self-checking bench of the dma interrupt flag block
`timescale 1ns/100ps
`default_nettype none
module test_dma_irq_clear_enable;
    // ****
    // stimulus and checks
    // ****
    logic        clk = 1'b0, rst = 1'b1, berr = 1'b0, wr = 1'b0, rd = 1'b0, irq, cen = 1'b1;
    logic [7:0]  done = 8'h00, req = 8'h00, ena = 8'h00;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wd = 32'h0000_0000, rdat, d;
    int          errors = 0, compares = 0, n;
    always #5 clk = ~clk;
    dirq_ctrl uut (.CLK(clk), .SYS_RST(rst), .CLK_EN(cen), .BUS_ERROR(berr), .CHAN_DONE(done),
        .CHAN_REQUEST(req), .CHAN_ENABLED(ena), .REG_ADDR(adr), .REG_WDATA(wd), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdat), .DMA_IRQ(irq));
    function automatic logic [31:0] live(input logic [31:0] v);
        return v & 32'h8000_00FF;
    endfunction : live
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
        compares++;
        if (v !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", s, e, v);
        end
    endtask : chk
    task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= w;
        rd <= r;
        adr <= a;
        wd <= v;
    endtask : bus
    task automatic rdc(input string s, input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, 1'b1, a, 32'h0000_0000);
        bus(1'b0, 1'b0, a, 32'h0000_0000);
        #1 chk(s, e, rdat);
    endtask : rdc
    task automatic wt(input logic [15:0] a, input logic [31:0] v);
        bus(1'b1, 1'b0, a, v);
        bus(1'b0, 1'b0, a, 32'h0000_0000);
        #1;
    endtask : wt
    task automatic test_done;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    initial begin
        void'($urandom(32'h8bd2));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc("enable", 16'h100C, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            d = i ? live($urandom) : 32'hFFFF_FFFF;
            bus(1'b1, 1'b0, 16'h100C, d);
            rdc("enable", 16'h100C, live(d));
        end
        wt(16'h1010, 32'hFFFF_FFFF);
        rdc("unmapped", 16'h1010, 32'h0000_0000);
        bus(1'b1, 1'b0, 16'h100C, 32'h8000_00FF);
        wt(16'h1004, 32'h8000_00FF);
        chk("irq", 32'h1, {31'h0, irq});
        d = live($urandom);
        wt(16'h1008, d);
        rdc("flag", 16'h1000, live(~d));
        wt(16'h1008, 32'h8000_00FF);
        chk("irq", 32'h0, {31'h0, irq});
        // odd channels raise a request while disabled, even ones finish
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            berr <= i == 8;
            done <= i[0] ? 8'h00 : 8'(1 << i);
            req <= i[0] ? 8'(1 << i) : 8'h00;
            n = 0;
            while (!irq && n < 12) begin
                @(posedge clk);
                n++;
            end
            if (n == 12) begin
                errors++;
                break;
            end
            {berr, req, done} <= 17'h0_0000;
            rdc("flag", 16'h1000, i == 8 ? 32'h8000_0000 : 32'h1 << i);
            repeat (6) @(posedge clk);
            wt(16'h1008, 32'h8000_00FF);
        end
        @(posedge clk);
        ena <= 8'hFF;
        req <= 8'hFF;
        repeat (8) @(posedge clk);
        rdc("flag", 16'h1000, 32'h0000_0000);
        wt(16'h1004, 32'h8000_00FF);
        wt(16'h100C, 32'h0000_0000);
        chk("irq", 32'h0, {31'h0, irq});
        // frozen clock enable: the write below must not land
        wt(16'h100C, 32'h8000_00FF);
        @(posedge clk);
        cen <= 1'b0;
        bus(1'b1, 1'b0, 16'h100C, 32'h0000_0000);
        bus(1'b0, 1'b0, 16'h100C, 32'h0000_0000);
        cen <= 1'b1;
        rdc("enable", 16'h100C, 32'h8000_00FF);
        chk("irq", 32'h1, {31'h0, irq});
        // reset in mid-run clears flags and enables
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc("enable", 16'h100C, 32'h0000_0000);
        rdc("flag", 16'h1000, 32'h0000_0000);
        chk("irq", 32'h0, {31'h0, irq});
        test_done();
    end
endmodule : test_dma_irq_clear_enable
bind dirq_ctrl dirq_assertions u_chk (.CLK, .SYS_RST, .CLK_EN, .BUS_ERROR, .CHAN_DONE,
    .CHAN_REQUEST, .CHAN_ENABLED, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .DMA_IRQ);
`default_nettype wire
